// file: psa_pkg.sv
package psa_pkg;

  // Register indexes on the management access path
  localparam logic [4:0] IDX_BASIC_STATUS   = 5'h01;
  localparam logic [4:0] IDX_IDENT_HIGH     = 5'h02;
  localparam logic [4:0] IDX_IDENT_LOW      = 5'h03;
  localparam logic [4:0] IDX_AUTONEG_ADVERT = 5'h04;

  // Basic status bit positions
  localparam int ST_T4      = 15;
  localparam int ST_TX_FD   = 14;
  localparam int ST_TX_HD   = 13;
  localparam int ST_T_FD    = 12;
  localparam int ST_T_HD    = 11;
  localparam int ST_AN_DONE = 5;
  localparam int ST_RFAULT  = 4;
  localparam int ST_AN_ABLE = 3;
  localparam int ST_LINK    = 2;
  localparam int ST_JABBER  = 1;
  localparam int ST_EXT_CAP = 0;

  // Identifier low field positions
  localparam int IDL_OUI_LSB   = 10;
  localparam int IDL_MODEL_LSB = 4;
  localparam int IDL_REV_LSB   = 0;

  // Advertisement field positions
  localparam int ADV_RFAULT    = 13;
  localparam int ADV_PAUSE_LSB = 10;
  localparam int ADV_ABIL_LSB  = 5;
  localparam int ADV_SEL_LSB   = 0;

  // Advertisement reset values
  localparam logic       ADV_RFAULT_RST = 1'b0;
  localparam logic [1:0] ADV_PAUSE_RST  = 2'h0;
  localparam logic [3:0] ADV_ABIL_RST   = 4'hf;
  localparam logic [4:0] ADV_SEL_RST    = 5'h01;

  // Pause encodings
  localparam logic [1:0] PAUSE_NONE = 2'h0;
  localparam logic [1:0] PAUSE_SYM  = 2'h1;
  localparam logic [1:0] PAUSE_ASYM = 2'h2;
  localparam logic [1:0] PAUSE_BOTH = 2'h3;

  // Resolved pause modes, at most one setting
  localparam logic [1:0] RES_NONE    = 2'h0;
  localparam logic [1:0] RES_SYM     = 2'h1;
  localparam logic [1:0] RES_ASYM_TX = 2'h2;
  localparam logic [1:0] RES_ASYM_RX = 2'h3;

  // Management request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [4:0]  index;
    logic [15:0] wdata;
  } psa_mgmt_req_t;

  // Live line conditions from the PHY core
  typedef struct packed {
    logic an_complete;
    logic remote_fault;
    logic link_up;
    logic jabber;
  } psa_line_t;

  // Advertised abilities as driven to the negotiation logic
  typedef struct packed {
    logic       remote_fault;
    logic [1:0] pause;
    logic [3:0] abilities;
    logic [4:0] selector;
  } psa_advert_t;

endpackage

// file: psa_latch_bit.sv
`timescale 1ns/1ps
module psa_latch_bit #(
  parameter bit HOLD_HIGH = 1'b1
) (
  input  wire logic clk_i,      // Management clock
  input  wire logic sys_rst_i,  // Sync reset, active high
  input  wire logic live_i,     // Live condition
  input  wire logic rd_i,       // Status read strobe
  output logic      flag_o      // Latched flag
);

  logic next_flag;

  // Hold the captured value until read, then track live; set wins over read
  always_comb begin
    if (HOLD_HIGH) begin
      next_flag = live_i | (flag_o & ~rd_i);
    end else begin
      next_flag = live_i & (flag_o | rd_i);
    end
  end

  // Register, reset to zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule

// file: psa_regs.sv
`timescale 1ns/1ps
// Operation
// RQ1: Status index 1 reads 0 in bit 15 and 1 in bits 14 to 11 for the four supported abilities.
// RQ2: Status bit 5 follows the negotiation-complete condition, 0 until done.
// RQ3: Status bit 4 goes high on a remote fault and stays high, 0 from reset.
// RQ4: Status bit 3 always reads 1 for negotiation ability.
// RQ5: Status bit 2 shows link, latches low on any loss, and resets to 0.
// RQ6: Status bit 1 goes high on jabber and stays high.
// RQ7: Status bit 0 always reads 1 for extended capability.
// RQ8: Index 2 is a writable 16-bit word holding identifier bits 3 to 18.
// RQ9: Index 3 holds identifier bits 19 to 24, a model field and a revision field, all writable.
// RQ10: Advertisement bit 13 is a writable remote-fault offer resetting to 0.
// RQ11: Advertisement bits 11 to 10 hold the pause offer, resetting to none.
// RQ12: After negotiation completes at most one pause setting is chosen.
// RQ13: Advertisement bits 8 to 5 offer the four abilities and reset to 1.
// RQ14: Registers are reached only by index through the management access port.
// RQ15: Latched status bits hold until status is read, then follow the live condition.
// RQ16: Reserved bits read 0 and ignore writes.
module psa_regs
  import psa_pkg::*;
#(
  parameter logic [15:0] ID_HIGH_RST  = 16'h1234,  // Arbitrary value
  parameter logic [5:0]  ID_OUI_RST   = 6'h2a,     // Arbitrary value
  parameter logic [5:0]  ID_MODEL_RST = 6'h15,     // Arbitrary value
  parameter logic [3:0]  ID_REV_RST   = 4'h1       // Arbitrary value
) (
  input  wire logic           clk_i,         // Management clock
  input  wire logic           sys_rst_i,     // Sync reset, active high
  input  psa_pkg::psa_mgmt_req_t mgmt_i,     // Indexed access request
  input  psa_pkg::psa_line_t  line_i,        // Live line conditions
  input  wire logic [1:0]     partner_pause_i, // Partner pause offer
  output logic [15:0]         rdata_o,       // Read data
  output logic                ack_o,         // Access done pulse
  output psa_pkg::psa_advert_t advert_o,     // Advertised abilities
  output logic [1:0]          pause_mode_o   // Resolved pause mode
);

  import psa_pkg::*;

  logic        status_rd;
  logic        rf_flag;
  logic        link_flag;
  logic        jab_flag;
  logic [15:0] status_word;
  logic [15:0] ident_high;
  logic [5:0]  ident_oui;
  logic [5:0]  ident_model;
  logic [3:0]  ident_rev;
  logic [15:0] next_ident_high;
  logic [5:0]  next_ident_oui;
  logic [5:0]  next_ident_model;
  logic [3:0]  next_ident_rev;
  psa_advert_t next_advert;
  logic [15:0] next_rdata;
  logic        next_ack;
  logic [1:0]  next_pause_mode;

  // Read or write hit on a given index
  function automatic logic hit(input psa_mgmt_req_t r, input logic [4:0] idx, input logic wr);
    hit = r.req && (r.we == wr) && (r.index == idx);
  endfunction

  // Status read releases latched bits to follow the live condition
  assign status_rd = hit(mgmt_i, IDX_BASIC_STATUS, 1'b0); // RQ15

  // Latching status bits
  psa_latch_bit #(.HOLD_HIGH(1'b1)) u_rfault (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .live_i    (line_i.remote_fault),
    .rd_i      (status_rd),
    .flag_o    (rf_flag)
  ); // RQ3
  psa_latch_bit #(.HOLD_HIGH(1'b0)) u_link (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .live_i    (line_i.link_up),
    .rd_i      (status_rd),
    .flag_o    (link_flag)
  ); // RQ5
  psa_latch_bit #(.HOLD_HIGH(1'b1)) u_jabber (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .live_i    (line_i.jabber),
    .rd_i      (status_rd),
    .flag_o    (jab_flag)
  ); // RQ6

  // Status word assembly, reserved bits zero
  always_comb begin
    status_word             = 16'h0000; // RQ16
    status_word[ST_T4]      = 1'b0; // RQ1
    status_word[ST_TX_FD]   = 1'b1; // RQ1
    status_word[ST_TX_HD]   = 1'b1; // RQ1
    status_word[ST_T_FD]    = 1'b1; // RQ1
    status_word[ST_T_HD]    = 1'b1; // RQ1
    status_word[ST_AN_DONE] = line_i.an_complete; // RQ2
    status_word[ST_RFAULT]  = rf_flag; // RQ3
    status_word[ST_AN_ABLE] = 1'b1; // RQ4
    status_word[ST_LINK]    = link_flag; // RQ5
    status_word[ST_JABBER]  = jab_flag; // RQ6
    status_word[ST_EXT_CAP] = 1'b1; // RQ7
  end

  // Identifier next values
  always_comb begin
    next_ident_high  = ident_high;
    next_ident_oui   = ident_oui;
    next_ident_model = ident_model;
    next_ident_rev   = ident_rev;
    if (hit(mgmt_i, IDX_IDENT_HIGH, 1'b1)) begin
      next_ident_high = mgmt_i.wdata; // RQ8
    end else if (hit(mgmt_i, IDX_IDENT_LOW, 1'b1)) begin
      next_ident_oui   = mgmt_i.wdata[IDL_OUI_LSB +: 6]; // RQ9
      next_ident_model = mgmt_i.wdata[IDL_MODEL_LSB +: 6]; // RQ9
      next_ident_rev   = mgmt_i.wdata[IDL_REV_LSB +: 4]; // RQ9
    end
  end

  // Identifier registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ident_high  <= ID_HIGH_RST;
      ident_oui   <= ID_OUI_RST;
      ident_model <= ID_MODEL_RST;
      ident_rev   <= ID_REV_RST;
    end else begin
      ident_high  <= next_ident_high;
      ident_oui   <= next_ident_oui;
      ident_model <= next_ident_model;
      ident_rev   <= next_ident_rev;
    end
  end

  // Advertisement next value, reserved bits dropped
  always_comb begin
    next_advert = advert_o;
    if (hit(mgmt_i, IDX_AUTONEG_ADVERT, 1'b1)) begin
      next_advert.remote_fault = mgmt_i.wdata[ADV_RFAULT]; // RQ10
      next_advert.pause        = mgmt_i.wdata[ADV_PAUSE_LSB +: 2]; // RQ11
      next_advert.abilities    = mgmt_i.wdata[ADV_ABIL_LSB +: 4]; // RQ13
      next_advert.selector     = mgmt_i.wdata[ADV_SEL_LSB +: 5]; // RQ16
    end
  end

  // Advertisement register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      advert_o.remote_fault <= ADV_RFAULT_RST; // RQ10
      advert_o.pause        <= ADV_PAUSE_RST; // RQ11
      advert_o.abilities    <= ADV_ABIL_RST; // RQ13
      advert_o.selector     <= ADV_SEL_RST;
    end else begin
      advert_o <= next_advert;
    end
  end

  // Indexed read path; unknown index reads zero
  always_comb begin
    next_rdata = rdata_o;
    next_ack   = mgmt_i.req; // RQ14
    if (hit(mgmt_i, IDX_BASIC_STATUS, 1'b0)) begin
      next_rdata = status_word;
    end else if (hit(mgmt_i, IDX_IDENT_HIGH, 1'b0)) begin
      next_rdata = ident_high; // RQ8
    end else if (hit(mgmt_i, IDX_IDENT_LOW, 1'b0)) begin
      next_rdata = {ident_oui, ident_model, ident_rev}; // RQ9
    end else if (hit(mgmt_i, IDX_AUTONEG_ADVERT, 1'b0)) begin
      next_rdata = 16'h0000; // RQ16
      next_rdata[ADV_RFAULT]         = advert_o.remote_fault;
      next_rdata[ADV_PAUSE_LSB +: 2] = advert_o.pause;
      next_rdata[ADV_ABIL_LSB +: 4]  = advert_o.abilities;
      next_rdata[ADV_SEL_LSB +: 5]   = advert_o.selector;
    end else if (mgmt_i.req && !mgmt_i.we) begin
      next_rdata = 16'h0000;
    end
  end

  // Pause resolution once negotiation is complete
  always_comb begin
    next_pause_mode = RES_NONE;
    if (line_i.an_complete) begin
      if (advert_o.pause[0] && partner_pause_i[0]) begin
        next_pause_mode = RES_SYM; // RQ12
      end else if (advert_o.pause == PAUSE_BOTH && partner_pause_i == PAUSE_ASYM) begin
        next_pause_mode = RES_ASYM_RX; // RQ12
      end else if (advert_o.pause == PAUSE_ASYM && partner_pause_i == PAUSE_BOTH) begin
        next_pause_mode = RES_ASYM_TX; // RQ12
      end
    end
  end

  // Read data, ack and pause mode registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o      <= 16'h0000;
      ack_o        <= 1'b0;
      pause_mode_o <= RES_NONE;
    end else begin
      rdata_o      <= next_rdata;
      ack_o        <= next_ack;
      pause_mode_o <= next_pause_mode;
    end
  end

endmodule

// file: psa_monitor.sv
`timescale 1ns/1ps
module psa_monitor
  import psa_pkg::*;
(
  input  wire logic            clk_i,            // Clock
  input  wire logic            sys_rst_i,        // Reset
  input  psa_pkg::psa_mgmt_req_t mgmt_i,         // Request
  input  psa_pkg::psa_line_t   line_i,           // Line levels
  input  wire logic [1:0]      partner_pause_i,  // Partner pause
  input  wire logic [15:0]     rdata_o,          // Read data
  input  wire logic            ack_o,            // Done pulse
  input  psa_pkg::psa_advert_t advert_o,         // Advert out
  input  wire logic [1:0]      pause_mode_o      // Pause mode
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Request decodes
  wire rd_st  = mgmt_i.req && !mgmt_i.we && mgmt_i.index == IDX_BASIC_STATUS;
  wire rd_adv = mgmt_i.req && !mgmt_i.we && mgmt_i.index == IDX_AUTONEG_ADVERT;
  wire wr_adv = mgmt_i.req && mgmt_i.we && mgmt_i.index == IDX_AUTONEG_ADVERT;
  // Handshake, status, advert and pause checks
  ack_follow_a: assert property (mgmt_i.req |=> ack_o) else $error("ack missing");
  ack_cause_a: assert property (ack_o |-> $past(mgmt_i.req)) else $error("stray ack");
  status_fixed_a: assert property (rd_st |=> rdata_o[15:6] == 10'h1e0 && rdata_o[3] && rdata_o[0])
    else $error("status constant bits wrong");
  an_done_a: assert property (rd_st |=> rdata_o[5] == $past(line_i.an_complete))
    else $error("negotiation done bit wrong");
  link_low_a: assert property (!line_i.link_up ##1 rd_st |=> !rdata_o[2]) else $error("link loss lost");
  fault_high_a: assert property (line_i.remote_fault ##1 rd_st |=> rdata_o[4]) else $error("fault lost");
  jabber_high_a: assert property (line_i.jabber ##1 rd_st |=> rdata_o[1]) else $error("jabber lost");
  adv_write_a: assert property (wr_adv |=> advert_o == $past({mgmt_i.wdata[13], mgmt_i.wdata[11:10],
    mgmt_i.wdata[8:0]})) else $error("advert write wrong");
  adv_reserved_a: assert property (rd_adv |=> rdata_o[15:14] == 2'h0 && !rdata_o[12] && !rdata_o[9])
    else $error("advert reserved bits set");
  pause_idle_a: assert property (!line_i.an_complete |=> pause_mode_o == RES_NONE)
    else $error("pause set before done");
  pause_sym_a: assert property (line_i.an_complete && advert_o.pause[0] && partner_pause_i[0]
    |=> pause_mode_o == RES_SYM) else $error("symmetric pause not chosen");
  // Main scenarios
  cover property (rd_st);
  cover property (wr_adv);
  cover property (pause_mode_o == RES_ASYM_RX);
endmodule

// file: psa_mac_model.sv
`timescale 1ns/1ps
module psa_mac_model
  import psa_pkg::*;
(
  input  wire logic        clk_i,    // Clock
  input  wire logic [15:0] rdata_i,  // Read data
  input  wire logic        ack_i,    // Done pulse
  output psa_pkg::psa_mgmt_req_t mgmt_o  // Request
);
  // Idle until the first access
  initial mgmt_o = '0;
  // One indexed access: one-cycle pulse, then collect the answer
  task automatic access(input logic we, input logic [4:0] idx, input logic [15:0] wd,
                        output logic ok, output logic [15:0] rd);
    @(negedge clk_i);
    mgmt_o <= '{req: 1'h1, we: we, index: idx, wdata: wd};
    @(negedge clk_i);
    mgmt_o <= '{req: 1'h0, we: ~we, index: ~idx, wdata: ~wd};
    ok = ack_i;
    rd = rdata_i;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
  import psa_pkg::*;
  typedef struct packed {logic we; logic [4:0] idx; logic [15:0] wd; logic [15:0] ex;} psa_row_t;
  logic          clk_i, sys_rst_i, ack_o, ok;
  logic [1:0]    partner_pause_i, pause_mode_o;
  logic [15:0]   rdata_o, rd;
  psa_mgmt_req_t mgmt_i;
  psa_line_t     line_i;
  psa_advert_t   advert_o;
  int            errors, cmp_count, cycles;
  logic [1:0]    pexp[4] = '{RES_NONE, RES_SYM, RES_ASYM_RX, RES_SYM};
  psa_row_t      rows[13] = '{
    '{1'h0, 5'h02, 16'h0, 16'h1234}, '{1'h0, 5'h03, 16'h0, 16'ha951}, '{1'h0, 5'h04, 16'h0, 16'h01e1},
    '{1'h0, 5'h07, 16'h0, 16'h0}, '{1'h1, 5'h02, 16'h5a5a, 16'h0}, '{1'h0, 5'h02, 16'h0, 16'h5a5a},
    '{1'h1, 5'h03, 16'hffff, 16'h0}, '{1'h0, 5'h03, 16'h0, 16'hffff}, '{1'h1, 5'h04, 16'hffff, 16'h0},
    '{1'h0, 5'h04, 16'h0, 16'h2dff}, '{1'h1, 5'h04, 16'h0, 16'h0}, '{1'h0, 5'h04, 16'h0, 16'h0},
    '{1'h1, 5'h01, 16'h0, 16'h0}};

  psa_regs i_psa_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mgmt_i(mgmt_i), .line_i(line_i),
    .partner_pause_i(partner_pause_i), .rdata_o(rdata_o), .ack_o(ack_o), .advert_o(advert_o),
    .pause_mode_o(pause_mode_o));
  psa_mac_model i_psa_mac_model (.clk_i(clk_i), .rdata_i(rdata_o), .ack_i(ack_o), .mgmt_o(mgmt_i));

  // Verdict and end of run
  task automatic final_report();
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Read with compare, write with ack check
  task automatic chk_rd(input logic [4:0] i, input logic [15:0] e);
    i_psa_mac_model.access(1'h0, i, 16'h0, ok, rd);
    `CHK("ack", 1'h1, ok)
    `CHK("rdata", e, rd)
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    i_psa_mac_model.access(1'h1, i, d, ok, rd);
    `CHK("ack", 1'h1, ok)
  endtask

  // Clock
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    sys_rst_i = 1'h1;
    line_i = '0;
    partner_pause_i = 2'h0;
    repeat (12) @(negedge clk_i);
    `CHK("rst advert", 12'h1e1, advert_o)
    `CHK("rst outs", 19'h0, {rdata_o, ack_o, pause_mode_o})
    sys_rst_i = 1'h0;
    foreach (rows[k]) begin
      if (rows[k].we) wr(rows[k].idx, rows[k].wd);
      else chk_rd(rows[k].idx, rows[k].ex);
    end
    line_i = 4'ha;
    repeat (2) @(negedge clk_i);
    chk_rd(IDX_BASIC_STATUS, 16'h7829);
    chk_rd(IDX_BASIC_STATUS, 16'h782d);
    // Events one cycle before the read, then held after the line recovers
    line_i = 4'hd;
    chk_rd(IDX_BASIC_STATUS, 16'h783b);
    line_i = 4'ha;
    chk_rd(IDX_BASIC_STATUS, 16'h783b);
    chk_rd(IDX_BASIC_STATUS, 16'h782d);
    line_i = 4'h2;
    repeat (2) @(negedge clk_i);
    chk_rd(IDX_BASIC_STATUS, 16'h780d);
    wr(IDX_AUTONEG_ADVERT, 16'h0de1);
    line_i = 4'ha;
    for (int p = 0; p < 4; p++) begin
      partner_pause_i = p[1:0];
      repeat (2) @(negedge clk_i);
      `CHK("pause", pexp[p], pause_mode_o)
    end
    wr(IDX_AUTONEG_ADVERT, 16'h09e1);
    repeat (2) @(negedge clk_i);
    `CHK("pause tx", RES_ASYM_TX, pause_mode_o)
    line_i = 4'h2;
    repeat (2) @(negedge clk_i);
    `CHK("pause off", RES_NONE, pause_mode_o)
    sys_rst_i = 1'h1;
    @(negedge clk_i);
    sys_rst_i = 1'h0;
    `CHK("rst2 outs", 19'h0, {rdata_o, ack_o, pause_mode_o})
    chk_rd(IDX_AUTONEG_ADVERT, 16'h01e1);
    chk_rd(IDX_IDENT_HIGH, 16'h1234);
    final_report();
  end
endmodule

bind psa_regs psa_monitor i_psa_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mgmt_i(mgmt_i),
  .line_i(line_i), .partner_pause_i(partner_pause_i), .rdata_o(rdata_o), .ack_o(ack_o),
  .advert_o(advert_o), .pause_mode_o(pause_mode_o));
